// *** core/gtm_prescaler.sv ***
// Selectable 1/8/64/256 prescaler in front of the timer count
`timescale 1ns/10ps
module gtm_prescaler
	import gtm_pkg::*;
(
	input  wire logic    clk_sys,
	input  wire logic    rstn,
	input  wire logic    timerOn,
	input  wire logic    srcTick,
	input  wire logic    clear,
	input  wire gtm_ps_e ps,
	output logic         outTick
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] lim;

	// Terminal count from the prescale select
	always_comb begin
		case (ps)
			PS_DIV1:   lim = PS_LIM_1;
			PS_DIV8:   lim = PS_LIM_8;
			PS_DIV64:  lim = PS_LIM_64;
			PS_DIV256: lim = PS_LIM_256;
			default:   lim = PS_LIM_1;
		endcase
	end

	// Clear only while the prescaler clock runs; divide otherwise
	always_comb begin
		cnt_nxt = cnt_r;
		outTick = 1'b0;
		if (timerOn && clear) begin
			cnt_nxt = 8'h00;
		end else if (timerOn && srcTick) begin
			if (cnt_r >= lim) begin
				cnt_nxt = 8'h00;
				outTick = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end
	end

	// Count register; device reset clears it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	psClear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		timerOn && clear |=> cnt_r == 8'h00) else $error("prescaler not cleared");
	psHalt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!timerOn |=> $stable(cnt_r)) else $error("prescaler moved while off");

endmodule // gtm_prescaler

// *** core/gtm_timer.sv ***
// Top of the 16-bit timer/counter with gate, prescaler, idle/sleep and RTC modes
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps

// Operation
// - Internal mode counts each instruction cycle to period, then wraps to zero.
// - Synchronous mode counts external rising edges aligned to the instruction cycle.
// - Asynchronous mode counts every external rising edge, wrapping after period match.
// - In Idle, stop-in-idle set halts counting; cleared lets it continue.
// - Gate mode counts instruction cycles only while gate pin is high.
// - Input clock passes a prescaler of 1, 8, 64 or 256.
// - Prescaler cleared by count write, control write and device reset.
// - With the timer off the prescaler is not cleared.
// - Writing control leaves the count unchanged; only a count write loads it.
// - In Sleep only enabled, external, asynchronous operation keeps counting.
// - Counting in Sleep wraps at period and may raise the interrupt.
// - Period match sets the sticky flag; request goes out when enabled.
// - Gate mode also sets the flag on the gate falling edge.
// - RTC mode counts low-power oscillator rising edges to period, then wraps.
// - Low-power oscillator enable disables normal modes, enables carry-out wake-up.
// - RTC keeps running in Sleep while oscillator runs and controls stay.
module gtm_timer
	import gtm_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire gtm_apb_req_s  apbReq,
	output gtm_apb_rsp_s       apbRsp,
	input  wire logic          extClkGatePin,
	input  wire logic          lpOscClk,
	input  wire logic          cpuIdle,
	input  wire logic          cpuSleep,
	output logic               timerIrqReq,
	output logic               wakeEvent
);
	import gtm_pkg::*;

	gtm_ctrl_s    ctrl_r, ctrl_nxt;
	gtm_apb_rsp_s rsp_r, rsp_nxt;
	logic [15:0]  count_r, count_nxt;
	logic [15:0]  period_r, period_nxt;
	logic         flag_r, flag_nxt;
	logic         irqEn_r, irqEn_nxt;
	logic         low_power_osc_enable_r, low_power_osc_enable_nxt;
	logic         irq_r, irq_nxt;
	logic         wake_r, wake_nxt;
	logic [1:0]   tcyCnt_r, tcyCnt_nxt;
	logic [1:0]   pinS1_r, pinS2_r, pinS3_r;
	logic [1:0]   pinLvl_r, pinLvl_nxt, pinPrev_r;
	logic         pend_r, pend_nxt;
	logic         tcyTick, extRise, lpRise, gateLvl, gateFall;
	logic         wrEn, wrCount, wrPeriod, wrControl, wrFlag, wrIrqEn, wrOsc;
	logic         srcTick, run, countStep, hit;
	logic [15:0]  ctrlWord;
	logic [15:0]  rdWord;
	logic         rdHit;

	// Register bus decode; a write takes effect in the completing access cycle
	always_comb begin
		wrEn      = apbReq.psel && apbReq.penable && rsp_r.pready && apbReq.pwrite;
		wrCount   = wrEn && (apbReq.paddr == ADDR_COUNT);
		wrPeriod  = wrEn && (apbReq.paddr == ADDR_PERIOD);
		wrControl = wrEn && (apbReq.paddr == ADDR_CONTROL);
		wrFlag    = wrEn && (apbReq.paddr == ADDR_IRQ_FLAG);
		wrIrqEn   = wrEn && (apbReq.paddr == ADDR_IRQ_EN);
		wrOsc     = wrEn && (apbReq.paddr == ADDR_OSC_CTL);
	end

	// Control word as software sees it; unused bits read zero
	always_comb begin
		ctrlWord = 16'h0000;
		ctrlWord[CTL_ON_BIT]            = ctrl_r.on;
		ctrlWord[CTL_SIDL_BIT]          = ctrl_r.stopIdle;
		ctrlWord[CTL_GATE_BIT]          = ctrl_r.gateEn;
		ctrlWord[CTL_PS_HI:CTL_PS_LO]   = ctrl_r.ps;
		ctrlWord[CTL_SYNC_BIT]          = ctrl_r.extSync;
		ctrlWord[CTL_CS_BIT]            = ctrl_r.clkSel;
	end

	// Read mux and error for unmapped addresses
	always_comb begin
		rdWord = 16'h0000;
		rdHit  = 1'b1;
		case (apbReq.paddr)
			ADDR_COUNT:    rdWord = count_r;
			ADDR_PERIOD:   rdWord = period_r;
			ADDR_CONTROL:  rdWord = ctrlWord;
			ADDR_IRQ_FLAG: rdWord[FLAG_BIT] = flag_r;
			ADDR_IRQ_EN:   rdWord[FLAG_BIT] = irqEn_r;
			ADDR_OSC_CTL:  rdWord[OSC_LPEN_BIT] = low_power_osc_enable_r;
			default:       rdHit = 1'b0;
		endcase
	end

	// Answer one cycle after setup, zero wait states in the access phase
	always_comb begin
		rsp_nxt = rsp_r;
		rsp_nxt.pready = 1'b0;
		if (apbReq.psel && !apbReq.penable) begin
			rsp_nxt.pready  = 1'b1;
			rsp_nxt.pslverr = !rdHit;
			rsp_nxt.prdata  = apbReq.pwrite ? 32'h0000_0000 : {16'h0000, rdWord};
		end
	end

	// Instruction cycle divider; the instruction clock stops in Sleep
	always_comb begin
		tcyCnt_nxt = tcyCnt_r + 2'b01;
		tcyTick    = (tcyCnt_r == TCY_LAST) && !cpuSleep;
	end

	// Pin filter: a change counts once stages two and three agree
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pinLvl_nxt[i] = (pinS2_r[i] == pinS3_r[i]) ? pinS3_r[i] : pinLvl_r[i];
		end
		extRise  = pinLvl_r[0] && !pinPrev_r[0];
		lpRise   = pinLvl_r[1] && !pinPrev_r[1];
		gateLvl  = pinLvl_r[0];
		gateFall = !pinLvl_r[0] && pinPrev_r[0];
	end

	// Edge held until the next instruction cycle in synchronous mode
	always_comb begin
		pend_nxt = extRise || (pend_r && !tcyTick);
	end

	// Source selection per mode
	always_comb begin
		srcTick = 1'b0;
		if (!ctrl_r.on) begin
			srcTick = 1'b0;
		end else if (low_power_osc_enable_r) begin
			srcTick = ctrl_r.clkSel && !ctrl_r.gateEn && lpRise;
		end else if (!ctrl_r.clkSel) begin
			srcTick = tcyTick && (!ctrl_r.gateEn || gateLvl);
		end else if (ctrl_r.extSync) begin
			srcTick = tcyTick && pend_r;
		end else begin
			srcTick = extRise;
		end
	end

	// Counting allowed by Idle and Sleep state
	always_comb begin
		run = ctrl_r.on
			&& !(cpuIdle && ctrl_r.stopIdle)
			&& (!cpuSleep || (ctrl_r.clkSel && !ctrl_r.extSync));
	end

	gtm_prescaler uPrescaler (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.timerOn (ctrl_r.on),
		.srcTick (srcTick && run),
		.clear   (wrCount || wrControl),
		.ps      (ctrl_r.ps),
		.outTick (countStep)
	);

	// Count, period, control and flag next values
	always_comb begin
		hit         = (count_r == period_r);
		count_nxt   = count_r;
		period_nxt  = wrPeriod ? apbReq.pwdata[15:0] : period_r;
		irqEn_nxt   = wrIrqEn ? apbReq.pwdata[FLAG_BIT] : irqEn_r;
		low_power_osc_enable_nxt = wrOsc ? apbReq.pwdata[OSC_LPEN_BIT] : low_power_osc_enable_r;
		ctrl_nxt    = ctrl_r;
		if (wrCount) begin
			count_nxt = apbReq.pwdata[15:0];
		end else if (countStep) begin
			count_nxt = hit ? 16'h0000 : count_r + 16'h0001;
		end
		if (wrControl) begin
			ctrl_nxt.on       = apbReq.pwdata[CTL_ON_BIT];
			ctrl_nxt.stopIdle = apbReq.pwdata[CTL_SIDL_BIT];
			ctrl_nxt.gateEn   = apbReq.pwdata[CTL_GATE_BIT];
			ctrl_nxt.ps       = gtm_ps_e'(apbReq.pwdata[CTL_PS_HI:CTL_PS_LO]);
			ctrl_nxt.extSync  = apbReq.pwdata[CTL_SYNC_BIT];
			ctrl_nxt.clkSel   = apbReq.pwdata[CTL_CS_BIT];
		end
		// Hardware set wins over a software clear in the same cycle
		flag_nxt = (countStep && hit)
			|| (gateFall && ctrl_r.on && ctrl_r.gateEn && !ctrl_r.clkSel && !low_power_osc_enable_r)
			|| (wrFlag ? apbReq.pwdata[FLAG_BIT] : flag_r);
		irq_nxt  = flag_r && irqEn_r;
		wake_nxt = low_power_osc_enable_r && countStep && hit;
	end

	// Register all state
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_r    <= gtm_ctrl_s'(RST_CONTROL[6:0]);
			rsp_r     <= '0;
			count_r   <= RST_COUNT;
			period_r  <= RST_PERIOD;
			flag_r    <= 1'b0;
			irqEn_r   <= 1'b0;
			low_power_osc_enable_r <= 1'b0;
			irq_r     <= 1'b0;
			wake_r    <= 1'b0;
			tcyCnt_r  <= 2'b00;
			pinS1_r   <= 2'b00;
			pinS2_r   <= 2'b00;
			pinS3_r   <= 2'b00;
			pinLvl_r  <= 2'b00;
			pinPrev_r <= 2'b00;
			pend_r    <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			rsp_r     <= rsp_nxt;
			count_r   <= count_nxt;
			period_r  <= period_nxt;
			flag_r    <= flag_nxt;
			irqEn_r   <= irqEn_nxt;
			low_power_osc_enable_r <= low_power_osc_enable_nxt;
			irq_r     <= irq_nxt;
			wake_r    <= wake_nxt;
			tcyCnt_r  <= tcyCnt_nxt;
			pinS1_r   <= {lpOscClk, extClkGatePin};
			pinS2_r   <= pinS1_r;
			pinS3_r   <= pinS2_r;
			pinLvl_r  <= pinLvl_nxt;
			pinPrev_r <= pinLvl_r;
			pend_r    <= pend_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign apbRsp      = rsp_r;
	assign timerIrqReq = irq_r;
	assign wakeEvent   = wake_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence seqGateFall;
		(ctrl_r.on && ctrl_r.gateEn && !ctrl_r.clkSel && !low_power_osc_enable_r && gateLvl)
		##1 (ctrl_r.on && ctrl_r.gateEn && !ctrl_r.clkSel && !low_power_osc_enable_r && !gateLvl);
	endsequence

	wrapZero_a: assert property (countStep && hit && !wrCount |=> count_r == 16'h0000)
		else $error("count did not wrap at period");
	countInc_a: assert property (countStep && !hit && !wrCount
		|=> count_r == $past(count_r) + 16'h0001)
		else $error("count did not advance by one");
	idleHold_a: assert property (cpuIdle && ctrl_r.stopIdle && !wrCount |=> $stable(count_r))
		else $error("count moved in idle");
	sleepHold_a: assert property (cpuSleep && !(ctrl_r.clkSel && !ctrl_r.extSync) && !wrCount
		|=> $stable(count_r))
		else $error("count moved in sleep");
	ctrlKeep_a: assert property (wrControl && !countStep |=> $stable(count_r))
		else $error("control write changed count");
	flagSet_a: assert property (countStep && hit |=> flag_r ##1 irq_r == $past(irqEn_r))
		else $error("match did not set flag");
	flagSticky_a: assert property (flag_r && !wrFlag |=> flag_r)
		else $error("flag cleared by hardware");
	gateFall_a: assert property (seqGateFall |=> flag_r)
		else $error("gate falling edge did not set flag");
	gateLow_a: assert property (ctrl_r.gateEn && !ctrl_r.clkSel && !low_power_osc_enable_r && !gateLvl
		&& !wrCount |=> $stable(count_r))
		else $error("gated count moved with gate low");
	syncAlign_a: assert property (ctrl_r.clkSel && ctrl_r.extSync && !low_power_osc_enable_r && !tcyTick
		&& !wrCount |=> $stable(count_r))
		else $error("synchronous count off the instruction cycle");

	// Register bus answer and count load
	readySetup_a: assert property (apbReq.psel && !apbReq.penable |=> rsp_r.pready)
		else $error("no answer after setup");
	readyOne_a: assert property (rsp_r.pready |=> !rsp_r.pready)
		else $error("pready stood longer than one cycle");
	countLoad_a: assert property (wrCount |=> count_r == $past(apbReq.pwdata[15:0]))
		else $error("count write did not load");

	// Interrupt request and wake-up outputs
	irqFollow_a: assert property (irq_r == $past(flag_r && irqEn_r))
		else $error("interrupt request does not follow flag and enable");
	wakeStep_a: assert property (low_power_osc_enable_r && countStep && hit |=> wake_r)
		else $error("no wake-up at carry-out");
	wakeOnly_a: assert property (wake_r |-> $past(low_power_osc_enable_r && countStep && hit))
		else $error("wake-up without carry-out");

	// Source selection per mode
	asyncEdge_a: assert property (ctrl_r.clkSel && !ctrl_r.extSync && !low_power_osc_enable_r
		&& !extRise && !wrCount |=> $stable(count_r))
		else $error("asynchronous count moved without a pin edge");
	internalTick_a: assert property (!ctrl_r.clkSel && !low_power_osc_enable_r && !tcyTick
		&& !wrCount |=> $stable(count_r))
		else $error("internal count moved off the instruction cycle");
	rtcOnly_a: assert property (low_power_osc_enable_r && !lpRise && !wrCount |=> $stable(count_r))
		else $error("normal mode counted with the oscillator enabled");

	sequence seqRtcStep;
		ctrl_r.on && ctrl_r.clkSel && !ctrl_r.gateEn && !ctrl_r.extSync && low_power_osc_enable_r
		&& cpuSleep && !(cpuIdle && ctrl_r.stopIdle) && (ctrl_r.ps == PS_DIV1)
		&& lpRise && !wrCount && !wrControl;
	endsequence

	rtcSleep_a: assert property (seqRtcStep
		|=> count_r == ($past(hit) ? 16'h0000 : $past(count_r) + 16'h0001))
		else $error("real-time clock stopped in sleep");

endmodule // gtm_timer

// *** inc/gtm_pkg.sv ***
// Package: register map, field layout, reset values and carriers of the 16-bit timer
package gtm_pkg;

	// Register indices; the APB byte address is four times the index
	localparam logic [11:0] IDX_COUNT    = 12'h100;
	localparam logic [11:0] IDX_PERIOD   = 12'h102;
	localparam logic [11:0] IDX_CONTROL  = 12'h104;
	localparam logic [11:0] IDX_IRQ_FLAG = 12'h106;
	localparam logic [11:0] IDX_IRQ_EN   = 12'h108;
	localparam logic [11:0] IDX_OSC_CTL  = 12'h10A;

	localparam int unsigned ADDR_W = 14;
	localparam logic [13:0] ADDR_COUNT    = {IDX_COUNT, 2'b00};
	localparam logic [13:0] ADDR_PERIOD   = {IDX_PERIOD, 2'b00};
	localparam logic [13:0] ADDR_CONTROL  = {IDX_CONTROL, 2'b00};
	localparam logic [13:0] ADDR_IRQ_FLAG = {IDX_IRQ_FLAG, 2'b00};
	localparam logic [13:0] ADDR_IRQ_EN   = {IDX_IRQ_EN, 2'b00};
	localparam logic [13:0] ADDR_OSC_CTL  = {IDX_OSC_CTL, 2'b00};

	// Control register field positions
	localparam int unsigned CTL_ON_BIT   = 15;
	localparam int unsigned CTL_SIDL_BIT = 13;
	localparam int unsigned CTL_GATE_BIT = 6;
	localparam int unsigned CTL_PS_HI    = 5;
	localparam int unsigned CTL_PS_LO    = 4;
	localparam int unsigned CTL_SYNC_BIT = 2;
	localparam int unsigned CTL_CS_BIT   = 1;
	localparam int unsigned OSC_LPEN_BIT = 1;
	localparam int unsigned FLAG_BIT     = 0;

	// Reset values
	localparam logic [15:0] RST_COUNT   = 16'h0000;
	localparam logic [15:0] RST_PERIOD  = 16'hFFFF;
	localparam logic [15:0] RST_CONTROL = 16'h0000;

	// Instruction cycle is the system clock divided by four
	localparam int unsigned TCY_DIV  = 4;
	localparam logic [1:0]  TCY_LAST = 2'(TCY_DIV - 1);

	// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
	localparam logic [7:0] PS_LIM_1   = 8'h00;
	localparam logic [7:0] PS_LIM_8   = 8'h07;
	localparam logic [7:0] PS_LIM_64  = 8'h3F;
	localparam logic [7:0] PS_LIM_256 = 8'hFF;

	typedef enum logic [1:0] {
		PS_DIV1,
		PS_DIV8,
		PS_DIV64,
		PS_DIV256
	} gtm_ps_e;

	typedef struct packed {
		logic    on;
		logic    stopIdle;
		logic    gateEn;
		gtm_ps_e ps;
		logic    extSync;
		logic    clkSel;
	} gtm_ctrl_s;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} gtm_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} gtm_apb_rsp_s;

endpackage

// *** tb/gtm_far_model.sv ***
// Far-side sources: external clock or gate pin, and low-power oscillator
`timescale 1ns/10ps
module gtm_far_model (
	input  wire logic clk_sys,
	input  wire logic extGo,
	input  wire logic gateLvl,
	input  wire logic lpGo,
	output logic      extClkGatePin,
	output logic      lpOscClk
);
	logic [3:0] extPh = 4'h0;
	logic [4:0] lpPh = 5'h00;

	// Phases advance only inside a burst, so both clocks stand still between bursts
	always @(posedge clk_sys) begin
		extPh <= extGo ? extPh + 4'h1 : 4'h0;
		lpPh <= lpGo ? lpPh + 5'h01 : 5'h00;
	end

	// Pin carries a 16-cycle clock in a burst, otherwise the gate level from the bench
	assign extClkGatePin = extGo ? extPh[3] : gateLvl;
	assign lpOscClk = lpGo & lpPh[4];
endmodule // gtm_far_model

// *** tb/gtm_timer_bench.sv ***
// Self-checking bench: APB accesses and timer modes against expected counts
`timescale 1ns/10ps
module gtm_timer_bench;
	import gtm_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rstn = 1'b0;
	gtm_apb_req_s apbReq = '0;
	gtm_apb_rsp_s apbRsp;
	gtm_apb_rsp_s rspS;
	logic         extGo = 1'b0;
	logic         lpGo = 1'b0;
	logic         gateLvl = 1'b0;
	logic         cpuIdle = 1'b0;
	logic         cpuSleep = 1'b0;
	logic         extPin;
	logic         lpClk;
	logic         irqReq;
	logic         wake;
	logic         irqS;
	logic [15:0]  q;
	logic [15:0]  cnt;
	logic         err;
	int           nWake = 0;
	int           w0;
	int           n_errors = 0;
	int           n_compared = 0;
	int           div [4] = '{1, 8, 64, 256};

	// Clock; answers and wake pulses are taken where they are settled
	always #5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) rspS = apbRsp;
	always @(negedge clk_sys) irqS = irqReq;
	always @(negedge clk_sys) if (wake === 1'b1) nWake = nWake + 1;

	gtm_timer i_dut (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.apbReq       (apbReq),
		.apbRsp       (apbRsp),
		.extClkGatePin(extPin),
		.lpOscClk     (lpClk),
		.cpuIdle      (cpuIdle),
		.cpuSleep     (cpuSleep),
		.timerIrqReq  (irqReq),
		.wakeEvent    (wake)
	);

	gtm_far_model i_far (
		.clk_sys      (clk_sys),
		.extGo        (extGo),
		.gateLvl      (gateLvl),
		.lpGo         (lpGo),
		.extClkGatePin(extPin),
		.lpOscClk     (lpClk)
	);

	// Closing report
	task results;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Compare within a tolerance; unknown values never match
	task chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
		n_compared++;
		if (((got + tol >= exp) && (got <= exp + tol)) !== 1'b1) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer: setup, access held until pready is seen high
	task apb(input logic w, input logic [13:0] a, input logic [15:0] d);
		int i;
		@(posedge clk_sys);
		apbReq <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (rspS.pready === 1'b1) break;
		end
		if (i < 20) begin
			q = rspS.prdata[15:0];
			err = rspS.pslverr;
			apbReq <= '0;
		end else begin
			n_errors++;
			$display("MISMATCH %0t no pready on the register bus", $time);
			results();
		end
	endtask

	task wr(input logic [13:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [13:0] a, input logic [15:0] exp, input int tol);
		apb(1'b0, a, 16'h0000);
		chk(q, exp, tol);
	endtask

	// Runs the external clock for n rising edges, then lets it settle
	task pulses(input int n);
		extGo <= 1'b1;
		repeat (16 * n) @(posedge clk_sys);
		extGo <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(ADDR_COUNT, RST_COUNT, 0);
		rd(ADDR_PERIOD, RST_PERIOD, 0);
		rd(ADDR_CONTROL, RST_CONTROL, 0);
		apb(1'b0, 14'h0004, 16'h0000);
		chk({15'h0000, err}, 16'h0001, 0);
		// Internal clock through every prescale code, stopped after about 20 steps
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_COUNT, 16'h0000);
			wr(ADDR_CONTROL, 16'h8000 | 16'(k << 4));
			repeat (80 * div[k]) @(posedge clk_sys);
			wr(ADDR_CONTROL, 16'(k << 4));
			rd(ADDR_COUNT, 16'd20, 1);
			cnt = q;
			wr(ADDR_CONTROL, 16'h0030);
			rd(ADDR_COUNT, cnt, 0);
		end
		// Period match sets a sticky flag; request follows the enable
		wr(ADDR_PERIOD, 16'h0003);
		wr(ADDR_COUNT, 16'h0000);
		wr(ADDR_CONTROL, 16'h8000);
		repeat (30) @(posedge clk_sys);
		wr(ADDR_CONTROL, 16'h0000);
		rd(ADDR_IRQ_FLAG, 16'h0001, 0);
		chk({15'h0000, irqS}, 16'h0000, 0);
		wr(ADDR_IRQ_EN, 16'h0001);
		rd(ADDR_IRQ_FLAG, 16'h0001, 0);
		chk({15'h0000, irqS}, 16'h0001, 0);
		wr(ADDR_IRQ_FLAG, 16'h0000);
		rd(ADDR_IRQ_FLAG, 16'h0000, 0);
		chk({15'h0000, irqS}, 16'h0000, 0);
		// Idle with stop-in-idle halts; without it counting goes on
		wr(ADDR_PERIOD, 16'hFFFF);
		wr(ADDR_COUNT, 16'h0000);
		cpuIdle <= 1'b1;
		wr(ADDR_CONTROL, 16'hA000);
		repeat (100) @(posedge clk_sys);
		rd(ADDR_COUNT, 16'h0000, 0);
		wr(ADDR_CONTROL, 16'h8000);
		repeat (40) @(posedge clk_sys);
		wr(ADDR_CONTROL, 16'h0000);
		rd(ADDR_COUNT, 16'd11, 2);
		cpuIdle <= 1'b0;
		// Sleep stops internal and synchronous counting
		cpuSleep <= 1'b1;
		wr(ADDR_COUNT, 16'h0000);
		wr(ADDR_CONTROL, 16'h8000);
		repeat (100) @(posedge clk_sys);
		rd(ADDR_COUNT, 16'h0000, 0);
		wr(ADDR_CONTROL, 16'h8006);
		pulses(5);
		rd(ADDR_COUNT, 16'h0000, 0);
		// Asynchronous counting goes on in Sleep and wraps at the period
		wr(ADDR_PERIOD, 16'h0003);
		wr(ADDR_CONTROL, 16'h8002);
		pulses(5);
		rd(ADDR_COUNT, 16'h0001, 0);
		rd(ADDR_IRQ_FLAG, 16'h0001, 0);
		wr(ADDR_IRQ_FLAG, 16'h0000);
		// Synchronous counting when awake
		cpuSleep <= 1'b0;
		wr(ADDR_PERIOD, 16'hFFFF);
		wr(ADDR_COUNT, 16'h0000);
		wr(ADDR_CONTROL, 16'h8006);
		pulses(7);
		rd(ADDR_COUNT, 16'h0007, 0);
		// Gated accumulation, flag on the gate falling edge
		wr(ADDR_COUNT, 16'h0000);
		wr(ADDR_CONTROL, 16'h8040);
		gateLvl <= 1'b1;
		repeat (80) @(posedge clk_sys);
		gateLvl <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rd(ADDR_COUNT, 16'd20, 1);
		rd(ADDR_IRQ_FLAG, 16'h0001, 0);
		// Low-power oscillator mode in Sleep; external pin is ignored
		wr(ADDR_IRQ_FLAG, 16'h0000);
		wr(ADDR_OSC_CTL, 16'h0002);
		wr(ADDR_PERIOD, 16'h0002);
		wr(ADDR_COUNT, 16'h0000);
		wr(ADDR_CONTROL, 16'h8002);
		cpuSleep <= 1'b1;
		w0 = nWake;
		lpGo <= 1'b1;
		pulses(6);
		lpGo <= 1'b0;
		rd(ADDR_COUNT, 16'h0000, 0);
		chk(16'(nWake - w0), 16'h0001, 0);
		results();
	end
endmodule // gtm_timer_bench
